// File: hw/socket_engine_pkg.sv
// Contract
// - UDP stores 8-byte header before payload
// - Drop whole packet exceeding receive free space
// - Resolve address unless destination repeats, is broadcast or is UDP multicast
// - Resolution failure sets timeout flag
// - UDP socket stays open after timeout
// - Close clears command, status goes closed
// - Open clears command once taken
// - Group addresses lie in 224-239 range
// - Group MAC is prefix plus 23 bits
// - Multicast open sends group join message
// - Version bit picks group protocol v1/v2
// - Mode 0010 opens UDP, reports UDP status
// - Mode 0011 opens raw IP socket
// - Known-MAC send skips address resolution
// - Plain UDP rejects multicast, optional broadcast
// - Multicast socket may block unicast, broadcast
// - Closed port answers unreachable unless blocked
// - Raw socket refuses TCP and UDP protocols
// - Raw ICMP socket stores echo requests
// - Raw packets stored behind 6-byte header
// - Send completion or timeout flag, write-one-clear
package socket_engine_pkg;
  localparam int CLK_PERIOD_NS     = 10;
  localparam int ARP_RETRY_TIME_US = 200000;
  localparam int ARP_RETRY_CYCLES  = ARP_RETRY_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int ARP_RETRY_COUNT   = 8;

  localparam logic [7:0] A_MODE     = 8'h00;
  localparam logic [7:0] A_CMD      = 8'h01;
  localparam logic [7:0] A_IRQ      = 8'h02;
  localparam logic [7:0] A_STATUS   = 8'h03;
  localparam logic [7:0] A_MODE_EXT = 8'h04;
  localparam logic [7:0] A_PROTO    = 8'h05;
  localparam logic [7:0] A_LPORT_H  = 8'h06;
  localparam logic [7:0] A_LPORT_L  = 8'h07;
  localparam logic [7:0] A_DIP      = 8'h08;
  localparam logic [7:0] A_DPORT_H  = 8'h0C;
  localparam logic [7:0] A_DPORT_L  = 8'h0D;
  localparam logic [7:0] A_DMAC     = 8'h10;
  localparam logic [7:0] A_CMODE    = 8'h18;
  localparam logic [7:0] A_RXWR_H   = 8'h1A;
  localparam logic [7:0] A_RXWR_L   = 8'h1B;
  localparam logic [7:0] A_RXRD_H   = 8'h1C;
  localparam logic [7:0] A_RXRD_L   = 8'h1D;

  localparam int MODE_MULTI = 7;
  localparam int MODE_IGMPV = 5;
  localparam int EXT_BCBLK  = 1;
  localparam int EXT_UCBLK  = 0;
  localparam int CMODE_PURB = 0;
  localparam int IRQ_SEND_COMPLETE_FLAG = 4;
  localparam int IRQ_TMO    = 3;
  localparam int IRQ_RECV   = 2;

  localparam logic [3:0] MODE_UDP   = 4'h2;
  localparam logic [3:0] MODE_IPRAW = 4'h3;
  localparam logic [7:0] CMD_NONE   = 8'h00;
  localparam logic [7:0] CMD_OPEN   = 8'h01;
  localparam logic [7:0] CMD_CLOSE  = 8'h10;
  localparam logic [7:0] CMD_SEND   = 8'h20;
  localparam logic [7:0] CMD_SENDM  = 8'h21;
  localparam logic [7:0] ST_CLOSED  = 8'h00;
  localparam logic [7:0] ST_UDP     = 8'h22;
  localparam logic [7:0] ST_IPRAW   = 8'h32;

  localparam logic [7:0]  IPP_ICMP  = 8'h01;
  localparam logic [7:0]  IPP_TCP   = 8'h06;
  localparam logic [7:0]  IPP_UDP   = 8'h11;
  localparam logic [3:0]  MC_LO     = 4'hE;
  localparam logic [31:0] IP_BCAST  = 32'hFFFFFFFF;
  localparam logic [23:0] MC_PREFIX = 24'h01005E;
  localparam logic [47:0] MAC_BCAST = 48'hFFFFFFFFFFFF;
  localparam logic [16:0] HDR_UDP   = 17'h00008;
  localparam logic [16:0] HDR_RAW   = 17'h00006;

  localparam logic [1:0] CL_UNI = 2'h0;
  localparam logic [1:0] CL_BC  = 2'h1;
  localparam logic [1:0] CL_MC  = 2'h2;
  localparam logic [1:0] TK_DATA = 2'h0;
  localparam logic [1:0] TK_JOIN = 2'h1;
  localparam logic [1:0] TK_UNR  = 2'h2;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_HDR = 4'h2, RX_PAY = 4'h4, RX_DROP = 4'h8
  } rx_state_type;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1, TX_ARP = 3'h2, TX_SEND = 3'h4
  } tx_state_type;
endpackage

// File: hw/udp_ipraw_socket_engine.sv
`timescale 1ns/10ps
module udp_ipraw_socket_engine
  import socket_engine_pkg::*;
#(
  parameter int RX_AW     = 11,
  parameter int ARP_WAIT  = ARP_RETRY_CYCLES,
  parameter int ARP_TRIES = ARP_RETRY_COUNT
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output      logic [7:0]       reg_rdata,
  input  wire logic             rx_start,
  input  wire logic             rx_is_udp,
  input  wire logic [7:0]       rx_proto,
  input  wire logic [1:0]       rx_class,
  input  wire logic [31:0]      rx_src_ip,
  input  wire logic [15:0]      rx_src_port,
  input  wire logic [15:0]      rx_dst_port,
  input  wire logic [15:0]      rx_len,
  input  wire logic             rx_port_open_other,
  input  wire logic [7:0]       rx_data,
  input  wire logic             rx_valid,
  input  wire logic             rx_last,
  output      logic             rx_ready,
  output      logic             buf_we,
  output      logic [RX_AW-1:0] buf_addr,
  output      logic [7:0]       buf_wdata,
  output      logic             arp_req,
  output      logic [31:0]      arp_ip,
  input  wire logic             arp_done,
  input  wire logic [47:0]      arp_mac,
  output      logic             tx_req,
  output      logic [1:0]       tx_kind,
  output      logic [31:0]      tx_dst_ip,
  output      logic [15:0]      tx_dst_port,
  output      logic [47:0]      tx_dst_mac,
  input  wire logic             tx_done,
  output      logic             igmp_v1,
  output      logic             echo_auto_reply
);
  if (RX_AW < 4 || RX_AW > 15 || ARP_WAIT < 1 || ARP_TRIES > 255) begin : g_bad
    $error("udp_ipraw_socket_engine: unsupported parameter value");
  end

  localparam logic [16:0] DEPTH = 17'(1 << RX_AW);

  function automatic logic is_mcast(input logic [31:0] ip);
    return ip[31:28] == MC_LO;
  endfunction
  function automatic logic [47:0] group_mac(input logic [31:0] ip);
    return {MC_PREFIX, 1'b0, ip[22:0]};
  endfunction

  logic [7:0]   mode_q, mode_ext_q, cmd_q, status_q, irq_q, proto_q, cmode_q;
  logic [7:0]   raw_proto_q;
  logic [15:0]  local_port_q, dest_port_q, wr_ptr_q, rd_ptr_q;
  logic [31:0]  dest_ip_q, last_ip_q, unr_ip_q;
  logic [47:0]  dest_mac_q, last_mac_q;
  logic [15:0]  unr_port_q, len_q, need_q, addr_q;
  logic         last_ok_q, ublk_q, bblk_q, mcast_q, join_q, unr_q;
  logic [63:0]  hdr_q;
  logic [3:0]   cnt_q;
  logic [31:0]  timer_q;
  logic [7:0]   tries_q;
  logic [7:0]   rd_val;
  rx_state_type rx_st, rx_d;
  tx_state_type tx_st;

  // Host register writes
  wire [7:0] ip_off  = reg_addr - A_DIP;
  wire [7:0] mac_off = reg_addr - A_DMAC;
  wire       dip_wr  = reg_wr && reg_addr >= A_DIP && ip_off < 8'h04;
  wire       dmac_wr = reg_wr && reg_addr >= A_DMAC && mac_off < 8'h06;

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q       <= 8'h00;
      mode_ext_q   <= 8'h00;
      proto_q      <= 8'h00;
      cmode_q      <= 8'h00;
      local_port_q <= 16'h0000;
      dest_port_q  <= 16'h0000;
      dest_ip_q    <= 32'h00000000;
      dest_mac_q   <= 48'h000000000000;
      rd_ptr_q     <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        A_MODE:     mode_q <= reg_wdata;
        A_MODE_EXT: mode_ext_q <= reg_wdata;
        A_PROTO:    proto_q <= reg_wdata;
        A_CMODE:    cmode_q <= reg_wdata;
        A_LPORT_H:  local_port_q[15:8] <= reg_wdata;
        A_LPORT_L:  local_port_q[7:0] <= reg_wdata;
        A_DPORT_H:  dest_port_q[15:8] <= reg_wdata;
        A_DPORT_L:  dest_port_q[7:0] <= reg_wdata;
        A_RXRD_H:   rd_ptr_q[15:8] <= reg_wdata;
        A_RXRD_L:   rd_ptr_q[7:0] <= reg_wdata;
        default: begin
          if (dip_wr)
            dest_ip_q[8*(3-int'(ip_off[1:0])) +: 8] <= reg_wdata;
          if (dmac_wr)
            dest_mac_q[8*(5-int'(mac_off[2:0])) +: 8] <= reg_wdata;
        end
      endcase
    end
  end

  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      A_MODE:     rd_val = mode_q;
      A_CMD:      rd_val = cmd_q;
      A_IRQ:      rd_val = irq_q;
      A_STATUS:   rd_val = status_q;
      A_MODE_EXT: rd_val = mode_ext_q;
      A_PROTO:    rd_val = proto_q;
      A_CMODE:    rd_val = cmode_q;
      A_LPORT_H:  rd_val = local_port_q[15:8];
      A_LPORT_L:  rd_val = local_port_q[7:0];
      A_DPORT_H:  rd_val = dest_port_q[15:8];
      A_DPORT_L:  rd_val = dest_port_q[7:0];
      A_RXWR_H:   rd_val = wr_ptr_q[15:8];
      A_RXWR_L:   rd_val = wr_ptr_q[7:0];
      A_RXRD_H:   rd_val = rd_ptr_q[15:8];
      A_RXRD_L:   rd_val = rd_ptr_q[7:0];
      default: begin
        if (reg_addr >= A_DIP && ip_off < 8'h04)
          rd_val = dest_ip_q[8*(3-int'(ip_off[1:0])) +: 8];
        if (reg_addr >= A_DMAC && mac_off < 8'h06)
          rd_val = dest_mac_q[8*(5-int'(mac_off[2:0])) +: 8];
      end
    endcase
  end

  // Command decode
  wire send_cmd  = cmd_q == CMD_SEND || cmd_q == CMD_SENDM;
  wire tx_idle   = tx_st == TX_IDLE;
  // Sends wait for the transmitter; other commands act at once
  wire cmd_take  = cmd_q != CMD_NONE &&
                   (!send_cmd || (tx_idle && !join_q && !unr_q));
  wire is_open   = cmd_take && cmd_q == CMD_OPEN;
  wire closing   = cmd_take && cmd_q == CMD_CLOSE;
  wire mc_sel    = mode_q[MODE_MULTI];
  wire udp_sel   = mode_q[3:0] == MODE_UDP;
  wire raw_ok    = mode_q[3:0] == MODE_IPRAW &&
                   proto_q != IPP_TCP && proto_q != IPP_UDP;
  wire open_udp  = is_open && udp_sel &&
                   (!mc_sel || is_mcast(dest_ip_q));
  wire open_raw  = is_open && raw_ok;
  wire status_udp_open  = status_q == ST_UDP;
  wire sock_raw  = status_q == ST_IPRAW;
  wire send_go   = cmd_take && send_cmd && (status_udp_open || sock_raw);

  // Transmit path decisions
  wire cache_hit = last_ok_q && last_ip_q == dest_ip_q;
  wire bc_dst    = dest_ip_q == IP_BCAST;
  wire mc_dst    = status_udp_open && is_mcast(dest_ip_q);
  wire direct    = cmd_q == CMD_SENDM || bc_dst || mc_dst || cache_hit;
  wire [47:0] direct_mac = cmd_q == CMD_SENDM ? dest_mac_q :
                           bc_dst ? MAC_BCAST :
                           mc_dst ? group_mac(dest_ip_q) : last_mac_q;
  wire arp_expire = tx_st == TX_ARP && !arp_done &&
                    timer_q == 32'(ARP_WAIT - 1);
  wire arp_fail   = arp_expire && tries_q == 8'(ARP_TRIES);
  wire join_take  = tx_idle && !closing && join_q;
  wire unr_take   = tx_idle && !closing && !join_q && unr_q;

  // Receive decisions, all before any byte is written
  logic cls_ok;
  always_comb begin
    case (rx_class)
      CL_UNI:  cls_ok = !(mcast_q && ublk_q);
      CL_BC:   cls_ok = !bblk_q;
      CL_MC:   cls_ok = mcast_q;
      default: cls_ok = 1'b0;
    endcase
  end
  wire        port_hit = status_udp_open && rx_is_udp && rx_dst_port == local_port_q;
  wire        udp_hit  = port_hit && cls_ok;
  // Echo requests reach here too when the socket serves ICMP
  wire        raw_hit  = sock_raw && !rx_is_udp &&
                         rx_proto == raw_proto_q;
  wire [16:0] hdr_len  = udp_hit ? HDR_UDP : HDR_RAW;
  wire [16:0] need     = {1'b0, rx_len} + hdr_len;
  wire [16:0] free_sp  = DEPTH - {1'b0, wr_ptr_q - rd_ptr_q};
  wire        fits     = need <= free_sp;
  wire        rx_new   = rx_st == RX_IDLE && rx_start;
  wire        take_pkt = rx_new && (udp_hit || raw_hit) && fits;
  wire        unr_hit  = rx_new && rx_is_udp && !port_hit &&
                         !rx_port_open_other && !cmode_q[CMODE_PURB];
  wire        pay_beat = rx_st == RX_PAY && rx_valid && rx_ready;
  wire        commit   = (rx_st == RX_HDR && cnt_q == 4'h1 &&
                          len_q == 16'h0000) || (pay_beat && rx_last);

  // Socket state, command and events
  wire [7:0] irq_set = {3'b000, tx_st == TX_SEND && tx_done &&
                        tx_kind == TK_DATA, arp_fail, commit, 2'b00};
  wire [7:0] irq_clr = (reg_wr && reg_addr == A_IRQ) ? reg_wdata : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q       <= CMD_NONE;
      status_q    <= ST_CLOSED;
      irq_q       <= 8'h00;
      ublk_q      <= 1'b0;
      bblk_q      <= 1'b0;
      mcast_q     <= 1'b0;
      raw_proto_q <= 8'h00;
      igmp_v1     <= 1'b0;
      join_q      <= 1'b0;
      reg_rdata   <= 8'h00;
      echo_auto_reply <= 1'b1;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 8'h00;
      irq_q     <= (irq_q & ~irq_clr) | irq_set;
      if (reg_wr && reg_addr == A_CMD)
        cmd_q <= reg_wdata;
      else if (cmd_take)
        cmd_q <= CMD_NONE;
      // A timeout never touches the status; only commands do
      if (open_udp)
        status_q <= ST_UDP;
      else if (open_raw)
        status_q <= ST_IPRAW;
      else if (closing || is_open)
        status_q <= ST_CLOSED;
      if (is_open) begin
        ublk_q      <= mode_ext_q[EXT_UCBLK];
        bblk_q      <= mode_ext_q[EXT_BCBLK];
        mcast_q     <= mc_sel && udp_sel;
        raw_proto_q <= proto_q;
        igmp_v1     <= mode_q[MODE_IGMPV];
      end
      join_q <= (open_udp && mc_sel) |
                (join_q && !join_take && !closing);
      echo_auto_reply <= !(sock_raw && raw_proto_q == IPP_ICMP);
    end
  end

  // Receive sequencer
  always_comb begin
    rx_d = rx_st;
    unique case (rx_st)
      RX_IDLE: begin
        if (take_pkt)
          rx_d = RX_HDR;
        else if (rx_start && rx_len != 16'h0000)
          rx_d = RX_DROP;
      end
      RX_HDR:  if (cnt_q == 4'h1) rx_d = len_q == 16'h0000 ? RX_IDLE : RX_PAY;
      RX_PAY:  if (pay_beat && rx_last) rx_d = RX_IDLE;
      RX_DROP: if (rx_valid && rx_last) rx_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st     <= RX_IDLE;
      rx_ready  <= 1'b0;
      wr_ptr_q  <= 16'h0000;
      addr_q    <= 16'h0000;
      hdr_q     <= 64'h0;
      cnt_q     <= 4'h0;
      len_q     <= 16'h0000;
      need_q    <= 16'h0000;
      buf_we    <= 1'b0;
      buf_addr  <= '0;
      buf_wdata <= 8'h00;
      unr_q     <= 1'b0;
      unr_ip_q  <= 32'h00000000;
      unr_port_q <= 16'h0000;
    end else begin
      rx_st    <= rx_d;
      rx_ready <= rx_d == RX_PAY || rx_d == RX_DROP;
      buf_we   <= rx_st == RX_HDR || pay_beat;
      buf_addr <= addr_q[RX_AW-1:0];
      buf_wdata <= rx_st == RX_HDR ? hdr_q[63:56] : rx_data;
      if (take_pkt) begin
        hdr_q  <= udp_hit ? {rx_src_ip, rx_src_port, rx_len}
                          : {rx_src_ip, rx_len, 16'h0000};
        cnt_q  <= hdr_len[3:0];
        addr_q <= wr_ptr_q;
        len_q  <= rx_len;
        need_q <= need[15:0];
      end else if (rx_st == RX_HDR || pay_beat) begin
        hdr_q  <= {hdr_q[55:0], 8'h00};
        cnt_q  <= cnt_q - 4'h1;
        addr_q <= addr_q + 16'h0001;
      end
      if (commit)
        wr_ptr_q <= wr_ptr_q + need_q;
      unr_q <= unr_hit | (unr_q & !unr_take);
      if (unr_hit) begin
        unr_ip_q   <= rx_src_ip;
        unr_port_q <= rx_src_port;
      end
    end
  end

  // Transmit sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st       <= TX_IDLE;
      tx_req      <= 1'b0;
      tx_kind     <= TK_DATA;
      tx_dst_ip   <= 32'h00000000;
      tx_dst_port <= 16'h0000;
      tx_dst_mac  <= 48'h000000000000;
      arp_req     <= 1'b0;
      arp_ip      <= 32'h00000000;
      timer_q     <= 32'h00000000;
      tries_q     <= 8'h00;
      last_ok_q   <= 1'b0;
      last_ip_q   <= 32'h00000000;
      last_mac_q  <= 48'h000000000000;
    end else begin
      tx_req  <= 1'b0;
      arp_req <= 1'b0;
      if (closing || is_open) begin
        tx_st     <= TX_IDLE;
        last_ok_q <= 1'b0;
      end else begin
        unique case (tx_st)
          TX_IDLE: begin
            if (join_take) begin
              tx_st       <= TX_SEND;
              tx_req      <= 1'b1;
              tx_kind     <= TK_JOIN;
              tx_dst_ip   <= dest_ip_q;
              tx_dst_port <= dest_port_q;
              tx_dst_mac  <= group_mac(dest_ip_q);
            end else if (unr_take) begin
              tx_st       <= TX_SEND;
              tx_req      <= 1'b1;
              tx_kind     <= TK_UNR;
              tx_dst_ip   <= unr_ip_q;
              tx_dst_port <= unr_port_q;
            end else if (send_go) begin
              tx_kind     <= TK_DATA;
              tx_dst_ip   <= dest_ip_q;
              tx_dst_port <= dest_port_q;
              arp_ip      <= dest_ip_q;
              timer_q     <= 32'h00000000;
              tries_q     <= 8'h00;
              if (direct) begin
                tx_st      <= TX_SEND;
                tx_req     <= 1'b1;
                tx_dst_mac <= direct_mac;
              end else begin
                tx_st   <= TX_ARP;
                arp_req <= 1'b1;
              end
            end
          end
          TX_ARP: begin
            timer_q <= timer_q + 32'h00000001;
            if (arp_done) begin
              tx_st      <= TX_SEND;
              tx_req     <= 1'b1;
              tx_dst_mac <= arp_mac;
              last_ok_q  <= 1'b1;
              last_ip_q  <= arp_ip;
              last_mac_q <= arp_mac;
            end else if (arp_fail) begin
              tx_st     <= TX_IDLE;
              last_ok_q <= 1'b0;
            end else if (arp_expire) begin
              timer_q <= 32'h00000000;
              tries_q <= tries_q + 8'h01;
              arp_req <= 1'b1;
            end
          end
          TX_SEND: if (tx_done) tx_st <= TX_IDLE;
        endcase
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_udp_hdr;
    take_pkt && udp_hit |=> ##1 buf_we[*8];
  endproperty
  a_udp_hdr: assert property (p_udp_hdr)
    else $error("header not 8 bytes");
  property p_drop;
    rx_new && !take_pkt |=> !buf_we ##1 (wr_ptr_q == $past(wr_ptr_q, 2));
  endproperty
  a_drop: assert property (p_drop)
    else $error("dropped packet stored");
  property p_arp_skip;
    tx_idle && send_go && !join_q && !unr_q && cache_hit |=> tx_st == TX_SEND;
  endproperty
  a_arp_skip: assert property (p_arp_skip)
    else $error("needless lookup");
  property p_arp_do;
    tx_idle && send_go && !join_q && !unr_q && !direct |=> arp_req;
  endproperty
  a_arp_do: assert property (p_arp_do) else $error("lookup skipped");
  property p_tmo;
    arp_fail && status_udp_open && !cmd_take |=>
      irq_q[IRQ_TMO] && status_q == ST_UDP;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout handling wrong");
  property p_close;
    cmd_q == CMD_CLOSE && !reg_wr |=> cmd_q == CMD_NONE &&
                                      status_q == ST_CLOSED;
  endproperty
  a_close: assert property (p_close) else $error("close not done");
  property p_open;
    is_open && udp_sel && !mc_sel && !reg_wr |=>
      cmd_q == CMD_NONE && status_q == ST_UDP;
  endproperty
  a_open: assert property (p_open) else $error("open not done");
  property p_mc_reject;
    rx_new && status_udp_open && rx_class == CL_MC && !mcast_q |=>
      rx_st != RX_HDR;
  endproperty
  a_mc_reject: assert property (p_mc_reject)
    else $error("bad accept");
  property p_ptr;
    commit |=> wr_ptr_q == $past(wr_ptr_q) + $past(need_q);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer wrong");
  property p_send_complete_flag;
    tx_st == TX_SEND && tx_done && tx_kind == TK_DATA |=> irq_q[IRQ_SEND_COMPLETE_FLAG];
  endproperty
  a_send_complete_flag: assert property (p_send_complete_flag) else $error("no send flag");

  c_store: cover property (commit ##1 irq_q[IRQ_RECV]);
  c_drop: cover property (rx_new && !fits && (udp_hit || raw_hit));
  c_tmo: cover property (arp_fail);
  c_join: cover property (tx_req && tx_kind == TK_JOIN);
endmodule

// File: verif/net_peer_model.sv
`timescale 1ns/10ps
module net_peer_model #(
  parameter logic [47:0] PEER_MAC = 48'h02A5C3000017
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mute,
  input  wire logic [7:0]  lat,
  input  wire logic        arp_req,
  output      logic        arp_done,
  output      logic [47:0] arp_mac,
  input  wire logic        tx_req,
  output      logic        tx_done
);
  logic [7:0] arp_cnt_q;
  logic [7:0] tx_cnt_q;
  logic       arp_wait_q;
  logic       tx_wait_q;
  // Idle lines show the inverse so a stale match cannot pass
  assign arp_mac = arp_done ? PEER_MAC : ~PEER_MAC;
  always_ff @(posedge clk) begin
    if (rst) begin
      {arp_wait_q, tx_wait_q, arp_done, tx_done} <= 4'h0;
    end else begin
      arp_done <= arp_wait_q && arp_cnt_q == 8'h00;
      tx_done  <= tx_wait_q && tx_cnt_q == 8'h00;
      // A muted peer never answers lookups, forcing retries
      if (arp_req && !mute) begin
        {arp_wait_q, arp_cnt_q} <= {1'b1, lat};
      end else if (arp_cnt_q == 8'h00) begin
        arp_wait_q <= 1'b0;
      end else begin
        arp_cnt_q <= arp_cnt_q - 8'h01;
      end
      if (tx_req) begin
        {tx_wait_q, tx_cnt_q} <= {1'b1, lat};
      end else if (tx_cnt_q == 8'h00) begin
        tx_wait_q <= 1'b0;
      end else begin
        tx_cnt_q <= tx_cnt_q - 8'h01;
      end
    end
  end
endmodule

// File: verif/udp_ipraw_socket_engine_tb.sv
`timescale 1ns/10ps
module udp_ipraw_socket_engine_tb;
  import socket_engine_pkg::*;
  typedef logic [7:0] bq_type[$];
  logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, mute = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, lat = 8'h00;
  logic        rx_start = 0, rx_is_udp = 0, rx_valid = 0, rx_last = 0;
  logic [7:0]  rx_proto = 8'h00, rx_data = 8'h00, buf_wdata;
  logic [1:0]  rx_class = 2'h0, tx_kind, kind;
  logic [31:0] rx_src_ip = 32'h0, arp_ip, tx_dst_ip;
  logic [15:0] rx_src_port = 16'h0, rx_dst_port = 16'h0, rx_len = 16'h0;
  logic [15:0] tx_dst_port;
  logic [47:0] arp_mac, tx_dst_mac;
  logic        rx_ready, buf_we, arp_req, arp_done, tx_req, tx_done;
  logic        igmp_v1, echo_auto_reply;
  logic [3:0]  buf_addr, wa = 4'h0;
  int          num_errors = 0, check_count = 0, arp_n = 0, tx_n = 0, k;
  bq_type      q;

  always #5 clk = ~clk;

  udp_ipraw_socket_engine #(.RX_AW(4), .ARP_WAIT(20), .ARP_TRIES(2))
  i_udp_ipraw_socket_engine (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_start(rx_start), .rx_is_udp(rx_is_udp),
    .rx_proto(rx_proto), .rx_class(rx_class), .rx_src_ip(rx_src_ip),
    .rx_src_port(rx_src_port), .rx_dst_port(rx_dst_port), .rx_len(rx_len),
    .rx_port_open_other(1'b0), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_ready(rx_ready), .buf_we(buf_we),
    .buf_addr(buf_addr), .buf_wdata(buf_wdata), .arp_req(arp_req),
    .arp_ip(arp_ip), .arp_done(arp_done), .arp_mac(arp_mac),
    .tx_req(tx_req), .tx_kind(tx_kind), .tx_dst_ip(tx_dst_ip),
    .tx_dst_port(tx_dst_port), .tx_dst_mac(tx_dst_mac), .tx_done(tx_done),
    .igmp_v1(igmp_v1), .echo_auto_reply(echo_auto_reply));

  net_peer_model i_net_peer_model (.clk(clk), .rst(rst), .mute(mute),
    .lat(lat), .arp_req(arp_req), .arp_done(arp_done), .arp_mac(arp_mac),
    .tx_req(tx_req), .tx_done(tx_done));

  always @(posedge clk) begin
    if (buf_we) begin
      q.push_back(buf_wdata);
      chk("buf addr", buf_addr, wa);
      wa++;
    end
    if (arp_req) arp_n++;
    if (tx_req) begin
      tx_n++;
      kind = tx_kind;
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string n, input logic [47:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", n, exp, seen);
    end
    if (k < 0) complete_run();
  endtask

  task automatic wr(input logic [7:0] a, v);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic dip(input logic [31:0] ip);
    for (int i = 0; i < 4; i++) wr(A_DIP + 8'(i), ip[31-8*i -: 8]);
  endtask

  // Sends n payload bytes; expects header plus payload when keep is set
  task automatic rx(input logic u, input logic [1:0] c, input logic [15:0] dp,
                    input int n, input logic keep);
    logic [31:0] ip;
    logic [15:0] sp;
    bq_type      e;
    ip = $urandom;
    sp = 16'($urandom);
    e = {ip[31:24], ip[23:16], ip[15:8], ip[7:0]};
    if (u) e = {e, sp[15:8], sp[7:0]};
    e = {e, 8'h00, 8'(n)};
    q.delete();
    @(posedge clk);
    {rx_start, rx_is_udp, rx_class, rx_dst_port} <= {1'b1, u, c, dp};
    {rx_len, rx_src_ip, rx_src_port, rx_proto} <= {16'(n), ip, sp, IPP_ICMP};
    @(posedge clk);
    rx_start <= 1'b0;
    for (k = 0; k < 40 && rx_ready !== 1'b1; k++) @(negedge clk);
    if (k == 40) k = -1;
    chk("rx_ready", rx_ready, 1'b1);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      e.push_back(8'($urandom));
      {rx_valid, rx_data, rx_last} <= {1'b1, e[e.size()-1], i == n - 1};
    end
    @(posedge clk);
    {rx_valid, rx_last} <= 2'b00;
    repeat (3) @(posedge clk);
    if (!keep) e.delete();
    chk("stored bytes", q.size(), e.size());
    foreach (e[i]) chk("stored byte", q[i], e[i]);
  endtask

  task automatic poll(input int b);
    d = 8'h00;
    for (k = 0; k < 300 && d[b] !== 1'b1; k++) rd(A_IRQ);
    if (k == 300) k = -1;
    chk("flag", d[b], 1'b1);
    wr(A_IRQ, 8'(1 << b));
  endtask

  task automatic txw(input int t);
    for (k = 0; k < 300 && tx_n < t; k++) @(negedge clk);
    if (k == 300) k = -1;
    chk("tx count", tx_n, t);
  endtask

  task automatic open_chk(input logic [7:0] m, st);
    wr(A_MODE, m);
    wr(A_CMD, CMD_OPEN);
    rd(A_CMD);
    chk("cmd", d, CMD_NONE);
    rd(A_STATUS);
    chk("status", d, st);
  endtask

  initial begin
    void'($urandom(32'h9d15));
    lat = 8'($urandom % 6);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("echo", echo_auto_reply, 1'b1);
    wr(A_LPORT_H, 8'h13);
    wr(A_LPORT_L, 8'h88);
    wr(A_MODE_EXT, 8'h02);
    open_chk({4'h0, MODE_UDP}, ST_UDP);
    rx(1, CL_UNI, 16'h1388, 3, 1);
    rd(A_RXWR_L);
    chk("wr ptr", d, 8'h0B);
    rx(1, CL_UNI, 16'h1388, 6, 0);
    rx(1, CL_MC, 16'h1388, 2, 0);
    rx(1, CL_BC, 16'h1388, 2, 0);
    rx(1, CL_UNI, 16'h0BB8, 1, 0);
    txw(1);
    chk("kind", kind, TK_UNR);
    wr(A_CMODE, 8'h01);
    rx(1, CL_UNI, 16'h0BB8, 1, 0);
    repeat (20) @(posedge clk);
    chk("tx count", tx_n, 1);
    dip({8'h0A, 24'($urandom)});
    repeat (2) begin
      wr(A_CMD, CMD_SEND);
      poll(IRQ_SEND_COMPLETE_FLAG);
      chk("lookups", arp_n, 1);
    end
    dip(32'h0A000001);
    wr(A_CMD, CMD_SENDM);
    poll(IRQ_SEND_COMPLETE_FLAG);
    chk("lookups", arp_n, 1);
    chk("mac", tx_dst_mac, 48'h0);
    dip(IP_BCAST);
    wr(A_CMD, CMD_SEND);
    poll(IRQ_SEND_COMPLETE_FLAG);
    chk("mac", tx_dst_mac, MAC_BCAST);
    chk("lookups", arp_n, 1);
    mute <= 1'b1;
    dip(32'h0A000002);
    wr(A_CMD, CMD_SEND);
    poll(IRQ_TMO);
    chk("arp ip", arp_ip, 32'h0A000002);
    rd(A_STATUS);
    chk("status", d, ST_UDP);
    wr(A_CMD, CMD_CLOSE);
    rd(A_CMD);
    chk("cmd", d, CMD_NONE);
    rd(A_STATUS);
    chk("status", d, ST_CLOSED);
    wr(A_PROTO, IPP_ICMP);
    wr(A_RXRD_L, 8'h0B);
    open_chk({4'h0, MODE_IPRAW}, ST_IPRAW);
    chk("echo", echo_auto_reply, 1'b0);
    rx(0, CL_UNI, 16'h0000, 2, 1);
    wr(A_CMD, CMD_CLOSE);
    wr(A_PROTO, IPP_TCP);
    open_chk({4'h0, MODE_IPRAW}, ST_CLOSED);
    dip(32'hE0000064);
    wr(A_DPORT_H, 8'h0B);
    wr(A_DPORT_L, 8'hB8);
    k = tx_n;
    open_chk(8'hA2, ST_UDP);
    txw(k + 1);
    chk("kind", kind, TK_JOIN);
    chk("v1", igmp_v1, 1'b1);
    chk("mac", tx_dst_mac, {MC_PREFIX, 24'h000064});
    chk("dst", {tx_dst_ip, tx_dst_port}, 48'hE00000640BB8);
    wr(A_RXRD_L, 8'h13);
    rx(1, CL_MC, 16'h1388, 2, 1);
    rx(1, CL_BC, 16'h1388, 1, 0);
    complete_run();
  end
endmodule
